// file: core/hbi_pkg.sv
// Constants shared by the host bus interface block
`default_nettype none
package hbi_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int IOS_W = 3;
   localparam int MS_W = 5;
   // I/O window: A15-A4 compared against base, A3-A0 select a register
   localparam int IO_REG_W = 4;
   localparam int IO_REGS = 16;
   localparam logic [11:0] IO_BASE_ROOT = 12'h020;
   // Memory window: A19-A14 compared, buffer RAM occupies 2K bytes
   localparam int RAM_BYTES = 2048;
   localparam int RAM_AW = 11;
   localparam int PKT_SLOTS = 4;
   localparam int PKT_MAX_BYTES = 508;
   localparam int MEM_BLK_LSB = 14;
   localparam logic [5:0] MEM_BASE_ROOT = 6'h30;
   // Narrow and wide 16-bit memory decode spans
   localparam int CS16_NARROW_LSB = 17;
   localparam int CS16_WIDE_LSB = 11;
   localparam int IOCS16_LSB = 2;
   // Ready stretch lengths in clocks, longer when the ROM is enabled
   localparam int STRETCH_NS = 100;
   localparam int STRETCH_ROM_NS = 200;
   localparam int CLK_NS = 4;
   localparam logic [7:0] STRETCH_CYC = 8'(STRETCH_NS / CLK_NS);
   localparam logic [7:0] STRETCH_ROM_CYC = 8'(STRETCH_ROM_NS / CLK_NS);
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // Register index of interrupt status and mask
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h1;
endpackage : hbi_pkg
`default_nettype wire

// file: core/hbi_ram.sv
// Byte-wide buffer RAM with two byte lanes
`default_nettype none
module hbi_ram #(
   parameter int AW = 11,
   parameter int DEPTH = 2048
) (
   input wire logic core_clk,
   input wire logic [AW-1:0] addr,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [7:0] mem_r [DEPTH];
   logic [AW-1:0] addr_hi;

   assign addr_hi = addr | AW'(1);
   assign rdata = {mem_r[addr_hi], mem_r[addr]};

   always_ff @(posedge core_clk) begin
      if (wr_lo) begin
         mem_r[addr] <= wdata[7:0];
      end
      if (wr_hi) begin
         mem_r[addr_hi] <= wdata[15:8];
      end
   end
endmodule : hbi_ram
`default_nettype wire

// file: core/hbi_top.sv
// Host expansion bus interface: decode, strobes, buffer RAM, data steering
`default_nettype none
module hbi_top
   import hbi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic host_por_in,
   input wire logic [hbi_pkg::ADDR_W-1:0] addr_in,
   input wire logic sbhe_n,
   input wire logic bale,
   input wire logic aen,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic rom_decode_enable_n,
   input wire logic [hbi_pkg::IOS_W-1:0] io_base_switch,
   input wire logic [hbi_pkg::MS_W-1:0] mem_base_switch,
   input wire logic [7:0] irq_status_in,
   input wire logic [hbi_pkg::DATA_W-1:0] data_in,
   output logic [hbi_pkg::DATA_W-1:0] data_out,
   output logic data_oe_lo,
   output logic data_oe_hi,
   output logic xcvr_dir_low_byte_n,
   output logic xcvr_dir_high_byte_n,
   output logic iochrdy_out,
   output logic iochrdy_oe,
   output logic zero_wait_out,
   output logic zero_wait_oe,
   output logic memcs16_out,
   output logic memcs16_oe,
   output logic iocs16_out,
   output logic iocs16_oe,
   output logic rom_select_n,
   output logic irq_out,
   output logic [7:0] irq_mask_out
);
   import hbi_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_STRETCH, ST_HOLD} hbi_rdy_type;

   logic [ADDR_W-1:0] addr_r;
   logic sbhe_n_r;
   logic [ADDR_W-1:0] addr_q;
   logic sbhe_q;
   logic [7:0] regs_r [IO_REGS];
   logic iow_n_r;
   logic memw_n_r;
   hbi_rdy_type rdy_r;
   hbi_rdy_type rdy_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [15:0] ram_rdata;
   logic [15:0] rd_data;
   logic [7:0] reg_rd;
   logic [7:0] reg_rd_hi;
   logic [3:0] reg_idx;
   logic reset_any;

   // Transparent latch modelled in core_clk: follow while BALE high
   assign addr_q = bale ? addr_in : addr_r;
   assign sbhe_q = bale ? sbhe_n : sbhe_n_r;
   assign reset_any = !rstn || host_por_in;

   // Window decode
   logic [11:0] io_base;
   logic [5:0] mem_base;
   logic io_hit;
   logic mem_hit;
   logic ram_hit;
   logic rom_hit;
   assign io_base = IO_BASE_ROOT + {5'h00, io_base_switch, 4'h0};
   assign mem_base = MEM_BASE_ROOT + {1'b0, mem_base_switch};
   assign io_hit = !aen && addr_q[15:4] == io_base;
   // Memory decode ignores AEN; lowest 2K (A13-A11 zero) RAM, remaining 14K ROM
   assign mem_hit = addr_q[ADDR_W-1:MEM_BLK_LSB] == mem_base;
   assign ram_hit = mem_hit && addr_q[MEM_BLK_LSB-1:RAM_AW] == 3'h0;
   assign rom_hit = mem_hit && !ram_hit && !rom_decode_enable_n;

   logic io_rd;
   logic io_wr;
   logic mem_rd;
   logic mem_wr;
   logic any_acc;
   logic hi_lane;
   assign io_rd = io_hit && !ior_n;
   assign io_wr = io_hit && !iow_n;
   assign mem_rd = (ram_hit || rom_hit) && !memr_n;
   assign mem_wr = ram_hit && !memw_n;
   assign any_acc = io_rd || io_wr || mem_rd || mem_wr;
   assign hi_lane = !sbhe_q;

   // Wide decode when ROM enabled: A19-A11, else A19-A17
   logic cs16_wide;
   logic cs16_narrow;
   logic memcs16_hit;
   logic iocs16_hit;
   assign cs16_narrow = addr_q[ADDR_W-1:CS16_NARROW_LSB]
      == mem_base[5:3];
   assign cs16_wide = addr_q[ADDR_W-1:CS16_WIDE_LSB]
      == {mem_base, 3'h0};
   assign memcs16_hit = rom_decode_enable_n ? cs16_narrow
      : cs16_wide;
   assign iocs16_hit = !aen && addr_q[15:IOCS16_LSB]
      == {io_base, 2'h0};

   // Register read mux; RAM offset taken from low address bits
   assign reg_idx = addr_q[IO_REG_W-1:0];
   assign reg_rd = regs_r[reg_idx];
   assign reg_rd_hi = regs_r[reg_idx | 4'h1];
   // ROM data comes from outside; device leaves data bus to the ROM
   assign rd_data = io_rd ? {reg_rd_hi, reg_rd} : ram_rdata;

   // Stretch ready once per access, longer with ROM enabled
   logic [7:0] stretch_len;
   assign stretch_len = rom_decode_enable_n ? STRETCH_CYC
      : STRETCH_ROM_CYC;
   always_comb begin
      rdy_nxt = rdy_r;
      cnt_nxt = cnt_r;
      case (rdy_r)
         ST_IDLE: begin
            if (any_acc) begin
               rdy_nxt = ST_STRETCH;
               cnt_nxt = stretch_len;
            end
         end
         ST_STRETCH: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r <= 8'h01) begin
               rdy_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!any_acc) begin
               rdy_nxt = ST_IDLE;
            end
         end
         default: begin
            rdy_nxt = ST_IDLE;
         end
      endcase
   end

   // Odd byte rides D15-D8 only while the host enables the high lane
   logic [7:0] odd_byte;
   logic [15:0] ram_wdata;
   assign odd_byte = hi_lane ? data_in[15:8] : data_in[7:0];
   assign ram_wdata = addr_q[0] ? {odd_byte, odd_byte} : data_in;

   hbi_ram #(
      .AW(RAM_AW),
      .DEPTH(RAM_BYTES)
   ) u_ram (
      .core_clk(core_clk),
      .addr(addr_q[RAM_AW-1:0]),
      .wr_lo(mem_wr && memw_n_r && !addr_q[0]),
      .wr_hi(mem_wr && memw_n_r && (hi_lane || addr_q[0])),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   always_ff @(posedge core_clk) begin
      if (reset_any) begin
         addr_r <= '0;
         sbhe_n_r <= 1'b1;
         iow_n_r <= 1'b1;
         memw_n_r <= 1'b1;
         rdy_r <= ST_IDLE;
         cnt_r <= 8'h00;
      end else begin
         addr_r <= addr_q;
         sbhe_n_r <= sbhe_q;
         iow_n_r <= iow_n;
         memw_n_r <= memw_n;
         rdy_r <= rdy_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Register file; write taken on strobe leading edge
   genvar gi;
   for (gi = 0; gi < IO_REGS; gi++) begin : g_reg
      logic wr_lo;
      logic wr_hi;
      assign wr_lo = io_wr && iow_n_r && reg_idx == 4'(gi);
      assign wr_hi = io_wr && iow_n_r && hi_lane
         && (reg_idx | 4'h1) == 4'(gi) && reg_idx != 4'(gi);
      always_ff @(posedge core_clk) begin
         if (reset_any) begin
            regs_r[gi] <= IRQ_RESET;
         end else if (4'(gi) == REG_STATUS) begin
            regs_r[gi] <= irq_status_in;
         end else if (wr_lo) begin
            regs_r[gi] <= data_in[7:0];
         end else if (wr_hi) begin
            regs_r[gi] <= data_in[15:8];
         end
      end
   end

   // Output flops; open-drain pins drive low only, enable when active
   always_ff @(posedge core_clk) begin
      if (reset_any) begin
         data_out <= '0;
         data_oe_lo <= 1'b0;
         data_oe_hi <= 1'b0;
         xcvr_dir_low_byte_n <= 1'b1;
         xcvr_dir_high_byte_n <= 1'b1;
         iochrdy_out <= 1'b0;
         iochrdy_oe <= 1'b0;
         zero_wait_out <= 1'b0;
         zero_wait_oe <= 1'b0;
         memcs16_out <= 1'b0;
         memcs16_oe <= 1'b0;
         iocs16_out <= 1'b0;
         iocs16_oe <= 1'b0;
         rom_select_n <= 1'b1;
         irq_out <= 1'b0;
         irq_mask_out <= IRQ_RESET;
      end else begin
         data_out <= rd_data;
         data_oe_lo <= io_rd || (mem_rd && !rom_hit);
         data_oe_hi <= (io_rd || (mem_rd && !rom_hit)) && hi_lane;
         xcvr_dir_low_byte_n <= !(io_rd || mem_rd);
         xcvr_dir_high_byte_n <= !((io_rd || mem_rd) && hi_lane);
         iochrdy_out <= 1'b0;
         iochrdy_oe <= rdy_nxt == ST_STRETCH;
         zero_wait_out <= 1'b0;
         // No zero-wait while stretching, the two would contradict
         zero_wait_oe <= any_acc && rdy_nxt != ST_STRETCH;
         memcs16_out <= 1'b0;
         memcs16_oe <= memcs16_hit;
         iocs16_out <= 1'b0;
         iocs16_oe <= iocs16_hit;
         rom_select_n <= !(rom_hit && !memr_n);
         irq_out <= |(regs_r[REG_STATUS] & regs_r[REG_MASK]);
         irq_mask_out <= regs_r[REG_MASK];
      end
   end
endmodule : hbi_top
`default_nettype wire

// file: verif/hbi_chk.sv
// Port-level checker for the host bus interface
`default_nettype none
module hbi_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic host_por_in,
   input wire logic aen,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic [7:0] irq_status_in,
   input wire logic data_oe_lo,
   input wire logic xcvr_dir_low_byte_n,
   input wire logic iochrdy_oe,
   input wire logic zero_wait_oe,
   input wire logic iocs16_oe,
   input wire logic rom_select_n,
   input wire logic irq_out,
   input wire logic [7:0] irq_mask_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rdy_cnt_r;
   // Stretch length can reach 50, too long to unroll
   always_ff @(posedge core_clk) begin
      if (!rstn || !iochrdy_oe) rdy_cnt_r <= 8'h00;
      else rdy_cnt_r <= rdy_cnt_r + 8'h01;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn || host_por_in);
   a_dir_on_drive: assert property (
      data_oe_lo |-> !xcvr_dir_low_byte_n)
      else $error("direction not toward host while driving");
   a_rom_dir: assert property (!rom_select_n |-> !xcvr_dir_low_byte_n)
      else $error("direction not toward host on rom read");
   a_aen_blocks_io: assert property (aen |=> !iocs16_oe)
      else $error("io flag with aen high");
   a_idle_no_drive: assert property (
      (ior_n && memr_n) [*2] |-> !data_oe_lo)
      else $error("data driven without read strobe");
   a_irq_mask: assert property (irq_out ==
      |($past(irq_status_in, 2) & irq_mask_out))
      else $error("interrupt disagrees with status and mask");
   a_rom_idle: assert property (memr_n [*2] |-> rom_select_n)
      else $error("rom select without memory read");
   a_ready_bound: assert property (rdy_cnt_r <= 8'h32)
      else $error("ready held low too long");
   a_zero_wait_access: assert property (zero_wait_oe |->
      $past(!(ior_n && iow_n && memr_n && memw_n)))
      else $error("zero wait flag without access");
   cover property (!rom_select_n);
   cover property (irq_out);
   cover property (iochrdy_oe ##1 !iochrdy_oe);
endmodule : hbi_chk
bind hbi_top hbi_chk hbi_chk_i (.core_clk, .rstn, .host_por_in, .aen, .ior_n,
   .iow_n, .memr_n, .memw_n, .irq_status_in, .data_oe_lo, .xcvr_dir_low_byte_n,
   .iochrdy_oe, .zero_wait_oe, .iocs16_oe, .rom_select_n, .irq_out,
   .irq_mask_out);
`default_nettype wire

// file: verif/hbi_host.sv
// Host processor bus model driving the expansion bus side
`default_nettype none
module hbi_host (
   input wire logic core_clk,
   input wire logic [15:0] rd_data,
   input wire logic rd_oe,
   input wire logic rom_sel_n,
   input wire logic rdy_oe,
   output logic [19:0] addr,
   output logic sbhe_n,
   output logic bale,
   output logic aen,
   output logic ior_n,
   output logic iow_n,
   output logic memr_n,
   output logic memw_n,
   output logic [15:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rd_q;
   logic oe_q, rom_q;
   int hangs;
   initial begin
      hangs = 0;
      {ior_n, iow_n, memr_n, memw_n, sbhe_n, aen, bale} = 7'h7e;
      addr = 20'h00000;
      data = 16'hffff;
   end
   // Kind 0 io read, 1 io write, 2 mem read, 3 mem write
   task automatic cyc(input logic [1:0] k, input logic [19:0] a,
      input logic [15:0] d, input logic sb, input logic en);
      int n;
      n = 0;
      @(posedge core_clk) #1;
      addr = a;
      sbhe_n = sb;
      aen = en;
      data = d;
      bale = 1'b1;
      @(posedge core_clk) #1;
      bale = 1'b0;
      // Hold time over: the latch alone keeps the address now
      addr = ~a;
      sbhe_n = ~sb;
      {ior_n, iow_n, memr_n, memw_n} = ~(4'h8 >> k);
      repeat (2) @(posedge core_clk);
      #1;
      while (rdy_oe && n < 200) begin
         @(posedge core_clk) #1;
         n++;
      end
      if (n >= 200) begin
         hangs++;
      end
      rd_q = rd_data;
      oe_q = rd_oe;
      rom_q = rom_sel_n;
      {ior_n, iow_n, memr_n, memw_n} = 4'hf;
      data = 16'hffff; // Released lines go to their pull-ups
      aen = 1'b1;
   endtask : cyc
endmodule : hbi_host
`default_nettype wire

// file: verif/hbi_bench.sv
// Self-checking bench for the host bus interface
`default_nettype none
module hbi_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Io block 0x020 plus switch 2 times 16; memory block 0x30 plus 1
   localparam logic [19:0] IO_A = 20'h00400;
   localparam logic [19:0] MEM_A = 20'hc4000;
   logic core_clk, rstn, host_por_in, sbhe_n, bale, aen, ior_n, iow_n;
   logic memr_n, memw_n, rom_decode_enable_n, data_oe_lo, iochrdy_oe;
   logic rom_select_n, irq_out;
   logic data_oe_hi, xcvr_dir_high_byte_n, iochrdy_out, zero_wait_out;
   logic zero_wait_oe, memcs16_out, memcs16_oe, iocs16_out, iocs16_oe;
   logic [19:0] addr_in;
   logic [15:0] data_in, data_out;
   logic [2:0] io_base_switch;
   logic [4:0] mem_base_switch;
   logic [7:0] irq_status_in;
   int errors, n_compared;
   hbi_top hbi_top_i (.core_clk, .rstn, .host_por_in, .addr_in, .sbhe_n,
      .bale, .aen, .ior_n, .iow_n, .memr_n, .memw_n, .rom_decode_enable_n,
      .io_base_switch, .mem_base_switch, .irq_status_in, .data_in, .data_out,
      .data_oe_lo, .data_oe_hi, .xcvr_dir_low_byte_n(),
      .xcvr_dir_high_byte_n, .iochrdy_out, .iochrdy_oe,
      .zero_wait_out, .zero_wait_oe, .memcs16_out, .memcs16_oe,
      .iocs16_out, .iocs16_oe, .rom_select_n, .irq_out, .irq_mask_out());
   hbi_host hbi_host_i (.core_clk, .rd_data(data_out), .rd_oe(data_oe_lo),
      .rom_sel_n(rom_select_n), .rdy_oe(iochrdy_oe), .addr(addr_in), .sbhe_n,
      .bale, .aen, .ior_n, .iow_n, .memr_n, .memw_n, .data(data_in));
   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rd_low(input string what, input logic [19:0] a,
      input logic [7:0] exp);
      hbi_host_i.cyc(2'h0, a, 16'h0000, 1'b1, 1'b0);
      chk(what, {8'h00, hbi_host_i.rd_q[7:0]}, {8'h00, exp});
   endtask : rd_low
   task automatic t_io_regs;
      hbi_host_i.cyc(2'h1, IO_A + 20'h1, 16'h0005, 1'b1, 1'b0);
      hbi_host_i.cyc(2'h1, IO_A + 20'h1, 16'h00ff, 1'b1, 1'b1);
      hbi_host_i.cyc(2'h1, IO_A + 20'h11, 16'h00ff, 1'b1, 1'b0);
      rd_low("mask", IO_A + 20'h1, 8'h05);
      chk("io drive", hbi_host_i.oe_q, 16'h0001);
      chk("hi lane off", data_oe_hi, 16'h0000);
      chk("io cs16", iocs16_oe, 16'h0001);
      chk("zero wait", zero_wait_oe, 16'h0001);
      chk("od low a", iochrdy_out | zero_wait_out, 16'h0000);
      chk("od low b", memcs16_out | iocs16_out, 16'h0000);
      irq_status_in = 8'h04;
      repeat (3) @(posedge core_clk);
      #1 chk("irq set", irq_out, 16'h0001);
      irq_status_in = 8'h02;
      rd_low("status", IO_A, 8'h02);
      chk("irq clear", irq_out, 16'h0000);
      hbi_host_i.cyc(2'h0, IO_A + 20'h11, 16'h0000, 1'b1, 1'b0);
      chk("miss drive", hbi_host_i.oe_q, 16'h0000);
      chk("miss cs16", iocs16_oe, 16'h0000);
      chk("miss zero wait", zero_wait_oe, 16'h0000);
   endtask : t_io_regs
   task automatic t_mem;
      // Aen high on purpose: memory decode must not care
      hbi_host_i.cyc(2'h3, MEM_A, 16'hbeef, 1'b0, 1'b1);
      hbi_host_i.cyc(2'h3, MEM_A, 16'h1234, 1'b1, 1'b1);
      hbi_host_i.cyc(2'h3, MEM_A + 20'h7fe, 16'h5aa5, 1'b0, 1'b0);
      hbi_host_i.cyc(2'h2, MEM_A, 16'h0000, 1'b0, 1'b1);
      chk("ram word", hbi_host_i.rd_q, 16'hbe34);
      chk("hi lane on", data_oe_hi, 16'h0001);
      chk("hi dir", xcvr_dir_high_byte_n, 16'h0000);
      chk("mem cs16", memcs16_oe, 16'h0001);
      hbi_host_i.cyc(2'h2, MEM_A + 20'h7fe, 16'h0000, 1'b0, 1'b0);
      chk("ram top", hbi_host_i.rd_q, 16'h5aa5);
      // Odd byte with the high lane off must come from D7-D0
      hbi_host_i.cyc(2'h3, MEM_A + 20'h3, 16'h0077, 1'b1, 1'b0);
      hbi_host_i.cyc(2'h2, MEM_A + 20'h3, 16'h0000, 1'b1, 1'b0);
      chk("odd byte", {8'h00, hbi_host_i.rd_q[7:0]}, 16'h0077);
   endtask : t_mem
   task automatic t_rom;
      rom_decode_enable_n = 1'b0;
      hbi_host_i.cyc(2'h2, MEM_A + 20'h800, 16'h0000, 1'b1, 1'b0);
      chk("rom select", hbi_host_i.rom_q, 16'h0000);
      chk("rom no drive", hbi_host_i.oe_q, 16'h0000);
      chk("cs16 wide", memcs16_oe, 16'h0000);
      rom_decode_enable_n = 1'b1;
      hbi_host_i.cyc(2'h2, MEM_A + 20'h800, 16'h0000, 1'b1, 1'b0);
      chk("rom off", hbi_host_i.rom_q, 16'h0001);
      chk("cs16 narrow", memcs16_oe, 16'h0001);
   endtask : t_rom
   task automatic t_por;
      host_por_in = 1'b1;
      @(posedge core_clk) #1;
      host_por_in = 1'b0;
      rd_low("mask after por", IO_A + 20'h1, 8'h00);
   endtask : t_por
   task automatic wrap_up;
      chk("host hangs", 16'(hbi_host_i.hangs), 16'h0000);
      $display("comparisons %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      #20000;
      errors++;
      wrap_up;
   end
   initial begin
      {rstn, host_por_in, rom_decode_enable_n} = 3'h1;
      io_base_switch = 3'h2;
      mem_base_switch = 5'h01;
      irq_status_in = 8'h00;
      errors = 0;
      n_compared = 0;
      repeat (3) @(posedge core_clk);
      #1 rstn = 1'b1;
      t_io_regs;
      t_mem;
      t_rom;
      t_por;
      wrap_up;
   end
endmodule : hbi_bench
`default_nettype wire
